// >>> inc/lsd_consts.svh
// Constants for the LED sink driver serial and mode logic
`ifndef LSD_CONSTS_SVH
`define LSD_CONSTS_SVH

// Channel count and width of the shift register and output latch
`define LSD_CH_COUNT      8
// Number of pin signals brought through the synchroniser
`define LSD_SYNC_BITS     12
// Index of the last shift edge of the mode switching phase
`define LSD_SWITCH_LAST   2'h1
// Reset values
`define LSD_SR_RST        8'h00
`define LSD_LATCH_RST     8'h00
`define LSD_EN_HIST_RST   2'h3
`define LSD_CNT_RST       2'h0
// Synchroniser reset: enable pin (bit 3) starts high, all else low
`define LSD_SYNC_RST      12'h008

`endif

// >>> inc/lsd_pkg.sv
// Types shared by the LED sink driver modules
`include "lsd_consts.svh"

package lsd_pkg;

	// Operating phase, Gray coded along normal, switching, detection
	typedef enum logic [1:0] {
		LSD_NORMAL = 2'h0,
		LSD_SWITCH = 2'h1,
		LSD_DETECT = 2'h3
	} lsd_mode_e;

	typedef logic [`LSD_CH_COUNT-1:0] lsd_chan_t;

endpackage : lsd_pkg

// >>> inc/lsd_sync_if.sv
// Synchronised pin levels passed from the synchroniser to the core
`timescale 1ns/1ps
`include "lsd_consts.svh"

interface lsd_sync_if;
	logic                    shift_clk;
	logic                    serial_in;
	logic                    strobe_mode_select;
	logic                    enable_switch_detect_n;
	logic [`LSD_CH_COUNT-1:0] channel_error;

	modport src (
		output shift_clk,
		output serial_in,
		output strobe_mode_select,
		output enable_switch_detect_n,
		output channel_error
	);

	modport dst (
		input shift_clk,
		input serial_in,
		input strobe_mode_select,
		input enable_switch_detect_n,
		input channel_error
	);
endinterface : lsd_sync_if

// >>> logic/lsd_pin_sync.sv
// Two-stage synchroniser for every pin that enters the system clock domain
`timescale 1ns/1ps
`include "lsd_consts.svh"

module lsd_pin_sync (
	input  wire logic                     sys_clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     shift_clk_i,
	input  wire logic                     serial_in_i,
	input  wire logic                     strobe_mode_select_i,
	input  wire logic                     enable_switch_detect_n_i,
	input  wire logic [`LSD_CH_COUNT-1:0] channel_error_i,
	lsd_sync_if.src                       sync
);

	localparam logic [`LSD_SYNC_BITS-1:0] RST_VEC = `LSD_SYNC_RST;

	logic      [`LSD_SYNC_BITS-1:0] raw;
	wire logic [`LSD_SYNC_BITS-1:0] sync_bits;

	// Pack pins; enable resets high below so drivers start blanked
	assign raw = {channel_error_i, enable_switch_detect_n_i,
		strobe_mode_select_i, serial_in_i, shift_clk_i};

	// First stage feeds only the second stage; each bit owns its flops
	// so that no vector is written from several processes
	genvar gi;
	generate
		for (gi = 0; gi < `LSD_SYNC_BITS; gi = gi + 1) begin : g_bit
			logic meta_r;
			logic sync_r;
			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					meta_r <= RST_VEC[gi];
					sync_r <= RST_VEC[gi];
				end else begin
					meta_r <= raw[gi];
					sync_r <= meta_r;
				end
			end
			assign sync_bits[gi] = sync_r;
		end
	endgenerate

	// Unpack synchronised levels
	assign sync.shift_clk              = sync_bits[0];
	assign sync.serial_in              = sync_bits[1];
	assign sync.strobe_mode_select     = sync_bits[2];
	assign sync.enable_switch_detect_n = sync_bits[3];
	assign sync.channel_error          = sync_bits[`LSD_SYNC_BITS-1:4];

endmodule : lsd_pin_sync

// >>> logic/lsd_top.sv
// Serial-in parallel-out control and mode logic of the LED sink driver
`timescale 1ns/1ps
`include "lsd_consts.svh"

// Overview of operation
// RQ1: Enable low drives sinks, high blanks all
// RQ2: One-clock enable pulse enters mode switching
// RQ3: Detection mode, enable low captures channel errors
// RQ4: Serial output presents outgoing shift register bit
// RQ5: Strobe latches data except while switching modes
// RQ6: Output enable works in every phase
// RQ7: Switching pulse recognised in every phase
// RQ8: Error capture happens only in detection mode
// RQ9: Strobe during switching never updates latch
// RQ10: Controller clocks captured errors out serially
// RQ11: Switching with select low returns to normal
// RQ12: Shift register shifts on shift clock rise
// RQ13: Latch transparent while strobe high, else holds
// RQ14: Select high picks detection, low picks normal
// RQ15: Latched one turns channel on when enabled
// RQ16: Serial output lags input by seven shifts
// RQ17: Start normal, hold mode until switching sequence

module lsd_top (
	input  wire logic                     sys_clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     shift_clk_i,
	input  wire logic                     serial_in_i,
	input  wire logic                     strobe_mode_select_i,
	input  wire logic                     enable_switch_detect_n_i,
	input  wire logic [`LSD_CH_COUNT-1:0] channel_error_i,
	output wire logic [`LSD_CH_COUNT-1:0] channel_sinks_o,
	output wire logic                     serial_out_o,
	output wire logic                     detect_mode_o
);

	lsd_sync_if sync ();

	lsd_pkg::lsd_chan_t  sr_r;
	lsd_pkg::lsd_chan_t  sr_nxt;
	lsd_pkg::lsd_chan_t  latch_r;
	lsd_pkg::lsd_chan_t  latch_nxt;
	lsd_pkg::lsd_chan_t  sinks_r;
	lsd_pkg::lsd_mode_e  state_r;
	lsd_pkg::lsd_mode_e  state_nxt;
	logic [1:0]          cnt_r;
	logic [1:0]          cnt_nxt;
	logic [1:0]          en_hist_r;
	logic                clk_prev_r;
	logic                clk_rise;
	logic                sw_pulse;
	logic                capture;
	logic                in_switch;
	logic                en_n;
	logic                strobe;

	// All pins pass two flip-flops before any logic here reads them
	lsd_pin_sync u_sync (
		.sys_clk_i                (sys_clk_i),
		.rst_n_i                  (rst_n_i),
		.shift_clk_i              (shift_clk_i),
		.serial_in_i              (serial_in_i),
		.strobe_mode_select_i     (strobe_mode_select_i),
		.enable_switch_detect_n_i (enable_switch_detect_n_i),
		.channel_error_i          (channel_error_i),
		.sync                     (sync)
	);

	// Event decode from synchronised levels
	assign en_n      = sync.enable_switch_detect_n;
	assign strobe    = sync.strobe_mode_select;
	assign clk_rise  = sync.shift_clk & ~clk_prev_r;
	assign in_switch = (state_r == lsd_pkg::LSD_SWITCH);
	// High, low, high on three shift edges is a switching pulse
	assign sw_pulse  = clk_rise & en_n & (en_hist_r == 2'h2); // RQ2 RQ7
	// Capture only in detection mode while enable is low
	assign capture   = clk_rise & ~en_n &
		(state_r == lsd_pkg::LSD_DETECT); // RQ3 RQ8

	// Capture has priority so the edge that senses errors does not shift
	assign sr_nxt = capture ? sync.channel_error : // RQ3
		clk_rise ? {sr_r[`LSD_CH_COUNT-2:0], sync.serial_in} : // RQ12
		sr_r;

	// Strobe is a data latch outside switching, mode select inside it
	assign latch_nxt = (strobe & ~in_switch) ? sr_r : latch_r; // RQ5 RQ9 RQ13

	// Mode machine; a new pulse restarts switching from any phase
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		if (sw_pulse) begin // RQ7
			state_nxt = lsd_pkg::LSD_SWITCH; // RQ2
			cnt_nxt   = `LSD_CNT_RST;
		end else if (clk_rise && in_switch) begin
			if (cnt_r == `LSD_SWITCH_LAST) begin
				state_nxt = strobe ? lsd_pkg::LSD_DETECT
					: lsd_pkg::LSD_NORMAL; // RQ11 RQ14
			end else begin
				cnt_nxt = cnt_r + 2'h1;
			end
		end
	end

	// Data path registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sr_r    <= `LSD_SR_RST;
			latch_r <= `LSD_LATCH_RST;
			sinks_r <= `LSD_LATCH_RST;
		end else begin
			sr_r    <= sr_nxt;
			latch_r <= latch_nxt;
			sinks_r <= latch_r & {`LSD_CH_COUNT{~en_n}}; // RQ1 RQ6 RQ15
		end
	end

	// Control registers; reset lands in normal mode
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r    <= lsd_pkg::LSD_NORMAL; // RQ17
			cnt_r      <= `LSD_CNT_RST;
			en_hist_r  <= `LSD_EN_HIST_RST;
			clk_prev_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			cnt_r      <= cnt_nxt;
			clk_prev_r <= sync.shift_clk;
			if (clk_rise) begin
				en_hist_r <= {en_hist_r[0], en_n};
			end
		end
	end

	// Last stage drives the cascade; controller reads errors here
	assign serial_out_o    = sr_r[`LSD_CH_COUNT-1]; // RQ4 RQ10 RQ16
	assign channel_sinks_o = sinks_r;
	assign detect_mode_o   = (state_r == lsd_pkg::LSD_DETECT);

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_blank_when_high: assert property ( // RQ1
		en_n |=> channel_sinks_o == '0)
		else $error("Sinks active while enable is high");

	a_sink_follows_latch: assert property ( // RQ15
		!en_n |=> channel_sinks_o == $past(latch_r))
		else $error("Sinks do not follow latch while enabled");

	a_switch_entry: assert property ( // RQ2
		sw_pulse |=> state_r == lsd_pkg::LSD_SWITCH && cnt_r == 2'h0)
		else $error("Switching pulse did not enter switching");

	a_pulse_in_switch: assert property ( // RQ7
		in_switch && sw_pulse |=> in_switch && cnt_r == 2'h0)
		else $error("Pulse during switching not restarted");

	a_detect_capture: assert property ( // RQ3
		capture |=> sr_r == $past(sync.channel_error))
		else $error("Error status not captured");

	a_shift_only: assert property ( // RQ8
		clk_rise && state_r != lsd_pkg::LSD_DETECT
		|=> sr_r[0] == $past(sync.serial_in)
			&& sr_r[7:1] == $past(sr_r[6:0]))
		else $error("Shift register did not shift");

	a_serial_stage: assert property ( // RQ16
		clk_rise && !capture |=> serial_out_o == $past(sr_r[6]))
		else $error("Serial output not next stage");

	a_latch_frozen: assert property ( // RQ9
		in_switch |=> latch_r == $past(latch_r))
		else $error("Latch changed during switching");

	a_latch_open: assert property ( // RQ13
		strobe && !in_switch |=> latch_r == $past(sr_r))
		else $error("Latch not transparent on strobe");

	a_mode_select: assert property ( // RQ14
		in_switch && clk_rise && !sw_pulse && cnt_r == 2'h1
		|=> state_r == ($past(strobe) ? lsd_pkg::LSD_DETECT
			: lsd_pkg::LSD_NORMAL))
		else $error("Wrong mode after switching");

	a_mode_hold: assert property ( // RQ17
		!in_switch && !sw_pulse |=> state_r == $past(state_r))
		else $error("Mode changed without switching");

	// Data path holds between shift events
	a_hold_no_rise: assert property ( // RQ12
		!clk_rise |=> sr_r == $past(sr_r))
		else $error("Shift register moved without shift edge");

	a_serial_hold: assert property ( // RQ16
		!clk_rise |=> $stable(serial_out_o))
		else $error("Serial output moved without shift edge");

	a_high_never_captures: assert property ( // RQ3
		clk_rise && en_n |=> sr_r[0] == $past(sync.serial_in))
		else $error("Capture while enable was high");

	a_latch_hold: assert property ( // RQ13
		!strobe |=> latch_r == $past(latch_r))
		else $error("Latch changed while strobe low");

	// Output enable in the switching phase and channel gating
	a_drive_in_switch: assert property ( // RQ6
		in_switch && !en_n |=> channel_sinks_o == $past(latch_r))
		else $error("Sinks not enabled during switching");

	a_zero_stays_off: assert property ( // RQ15
		!en_n && latch_r == '0 |=> channel_sinks_o == '0)
		else $error("Sink on for a latched zero");

	// Switching phase counts shift events only
	a_switch_count: assert property ( // RQ14
		in_switch && clk_rise && !sw_pulse && cnt_r == 2'h0
		|=> in_switch && cnt_r == 2'h1)
		else $error("Switching phase did not count shift");

	a_switch_idle: assert property ( // RQ17
		in_switch && !clk_rise |=> in_switch && cnt_r == $past(cnt_r))
		else $error("Switching phase moved without shift");

endmodule : lsd_top

// >>> verification/lsd_ctrl_model.sv
// Controller model driving shift clock, data, strobe and enable pins
`timescale 1ns/1ps

module lsd_ctrl_model (
	input  wire logic sys_clk_i,
	output logic      shift_clk_o,
	output logic      serial_in_o,
	output logic      strobe_mode_select_o,
	output logic      enable_switch_detect_n_o
);
	// Idle pins: clock low, drivers blanked
	initial begin
		shift_clk_o = 1'b0;
		serial_in_o = 1'b0;
		strobe_mode_select_o = 1'b0;
		enable_switch_detect_n_o = 1'b1;
	end

	task automatic wait_n(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask : wait_n

	// Pins move at the falling edge, away from the sampling edge
	task automatic set_pins(input logic en, input logic st);
		@(negedge sys_clk_i);
		enable_switch_detect_n_o = en;
		strobe_mode_select_o = st;
	endtask : set_pins

	// Phases of three cycles or more, since pins pass a synchroniser
	task automatic shift(input logic d, input logic en, input logic st);
		set_pins(en, st);
		serial_in_o = d;
		wait_n(3);
		shift_clk_o = 1'b1;
		wait_n(4);
		shift_clk_o = 1'b0;
		wait_n(3);
		serial_in_o = ~d; // Data is stale once the hold time is over
	endtask : shift

	task automatic strobe_pulse();
		set_pins(enable_switch_detect_n_o, 1'b1);
		wait_n(4);
		strobe_mode_select_o = 1'b0;
		wait_n(4);
	endtask : strobe_pulse
endmodule : lsd_ctrl_model

// >>> verification/tb_top.sv
// Self-checking testbench of the LED sink driver control logic
`timescale 1ns/1ps

module tb_top;
	logic       sys_clk_i = 1'b0;
	logic       rst_n_i;
	logic       shift_clk, serial_in, strobe, enable_n, serial_out, det;
	logic [7:0] err, sinks, exp_sr, exp_latch;
	logic       in_det;
	int         fail_count, n_tests;

	always #10 sys_clk_i = ~sys_clk_i;

	lsd_ctrl_model lsd_ctrl_model_inst (
		.sys_clk_i(sys_clk_i), .shift_clk_o(shift_clk),
		.serial_in_o(serial_in), .strobe_mode_select_o(strobe),
		.enable_switch_detect_n_o(enable_n)
	);

	lsd_top lsd_top_inst (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .shift_clk_i(shift_clk),
		.serial_in_i(serial_in), .strobe_mode_select_i(strobe),
		.enable_switch_detect_n_i(enable_n), .channel_error_i(err),
		.channel_sinks_o(sinks), .serial_out_o(serial_out),
		.detect_mode_o(det)
	);

	task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic results();
		if (fail_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	// One shift, followed in a reference copy of the shift register
	task automatic shift(input logic d, input logic en, input logic st);
		lsd_ctrl_model_inst.shift(d, en, st);
		if (in_det && !en) exp_sr = err;
		else exp_sr = {exp_sr[6:0], d};
		chk("serial_out", {7'h00, serial_out}, {7'h00, exp_sr[7]});
	endtask : shift

	// Shift a byte MSB first with drivers on, strobe it if asked
	task automatic load(input logic [7:0] v, input logic st);
		for (int i = 7; i >= 0; i--) shift(v[i], 1'b0, 1'b0);
		if (st) begin
			lsd_ctrl_model_inst.strobe_pulse();
			exp_latch = exp_sr;
		end
		lsd_ctrl_model_inst.wait_n(4);
		chk("sinks", sinks, exp_latch);
	endtask : load

	// Enable samples 1,0,1 on three shifts, then two more pick the mode
	task automatic mode_switch(input logic sel);
		shift(1'b0, 1'b1, 1'b0);
		shift(1'b1, 1'b0, 1'b0);
		shift(1'b0, 1'b1, 1'b0);
		lsd_ctrl_model_inst.set_pins(1'b0, 1'b0);
		lsd_ctrl_model_inst.strobe_pulse();
		lsd_ctrl_model_inst.wait_n(4);
		chk("sinks while switching", sinks, exp_latch);
		shift(1'b1, 1'b1, 1'b0);
		shift(1'b1, 1'b1, sel);
		lsd_ctrl_model_inst.set_pins(1'b1, 1'b0);
		in_det = sel;
		if (sel) exp_latch = exp_sr;
		chk("detect_mode", {7'h00, det}, {7'h00, sel});
	endtask : mode_switch

	initial begin
		rst_n_i = 1'b0;
		err = 8'h96;
		exp_sr = 8'h00;
		exp_latch = 8'h00;
		in_det = 1'b0;
		fail_count = 0;
		n_tests = 0;
		repeat (16) @(posedge sys_clk_i);
		@(negedge sys_clk_i) rst_n_i = 1'b1;
		chk("sinks at reset", sinks, 8'h00);
		chk("mode at reset", {7'h00, det}, 8'h00);
		load(8'ha5, 1'b1);
		lsd_ctrl_model_inst.set_pins(1'b1, 1'b0);
		lsd_ctrl_model_inst.wait_n(4);
		chk("blanked sinks", sinks, 8'h00);
		load(8'h3c, 1'b0);
		mode_switch(1'b1);
		// Two low samples capture twice; a lone low between highs
		// would also form a switching pulse and leave detection
		shift(1'b0, 1'b0, 1'b0);
		shift(1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 7; i++) shift(1'b1, 1'b1, 1'b0);
		chk("mode after read", {7'h00, det}, 8'h01);
		lsd_ctrl_model_inst.set_pins(1'b0, 1'b0);
		lsd_ctrl_model_inst.strobe_pulse();
		exp_latch = exp_sr;
		lsd_ctrl_model_inst.wait_n(4);
		chk("sinks in detection", sinks, exp_latch);
		mode_switch(1'b0);
		load(8'h5a, 1'b1);
		results();
	end
endmodule : tb_top
